// File: hw/scam_map.svh
// Word addresses, command values and reset values of the servo address map.
// Assumes inclusion by bare name from the package and the map module.
`ifndef SCAM_MAP_SVH
`define SCAM_MAP_SVH

`define SCAM_PAR_FIRST 16'h0000
`define SCAM_PAR_LAST 16'h02fd
`define SCAM_HIST_FIRST 16'h07f1
`define SCAM_HIST_LAST 16'h07fa
`define SCAM_HIST_DEPTH 10
`define SCAM_SPD_OFS 16'h07fb
`define SCAM_TRQ_OFS 16'h07fc
`define SCAM_IU_OFS 16'h07fd
`define SCAM_IV_OFS 16'h07fe
`define SCAM_MON_SPD_FB 16'h0806
`define SCAM_MON_SPD_IN 16'h0807
`define SCAM_MON_TRQ_IN 16'h0808
`define SCAM_MON_TRQ_INT 16'h0809
`define SCAM_MON_ENC_PLS 16'h080a
`define SCAM_MON_IN_PINS 16'h080b
`define SCAM_MON_ENC_LINES 16'h080c
`define SCAM_MON_OUT_PINS 16'h080d
`define SCAM_MON_PLS_SET 16'h080e
`define SCAM_MON_LOC_LO 16'h080f
`define SCAM_MON_LOC_HI 16'h0810
`define SCAM_MON_FERR_LO 16'h0811
`define SCAM_MON_FERR_HI 16'h0812
`define SCAM_MON_CMDP_LO 16'h0813
`define SCAM_MON_CMDP_HI 16'h0814
`define SCAM_MON_INERTIA 16'h0815
`define SCAM_MON_OVERLOAD 16'h0816
`define SCAM_ALARM_NOW 16'h0817
`define SCAM_WINDING_TEMP 16'h0818
`define SCAM_LINK_IO 16'h0900
`define SCAM_MAIN_VER 16'h090e
`define SCAM_LOGIC_VER 16'h090f
`define SCAM_ABS_TURNS 16'h1010
`define SCAM_ABS_ANGLE_LO 16'h1011
`define SCAM_ABS_ANGLE_HI 16'h1012
`define SCAM_CMD_HIST_CLR 16'h1021
`define SCAM_CMD_ALARM_CLR 16'h1022
`define SCAM_CMD_JOG_EN 16'h1023
`define SCAM_CMD_JOG_FWD 16'h1024
`define SCAM_CMD_JOG_REV 16'h1025
`define SCAM_CMD_NODE_FWD 16'h1026
`define SCAM_CMD_NODE_REV 16'h1027
`define SCAM_CMD_NODE_PAUSE 16'h1028
`define SCAM_CMD_ENC_CLR 16'h1040
`define SCAM_CMD_TURNS_CLR 16'h1041
`define SCAM_CMD_TEACH 16'h1070
`define SCAM_VAL_OFF 16'h0000
`define SCAM_VAL_ON 16'h0001
`define SCAM_RST_WORD 16'h0000
`define SCAM_MAIN_VER_DEFAULT 16'h0100
`define SCAM_LOGIC_VER_DEFAULT 16'h0100

`endif

// File: hw/scam_pkg.sv
// Types shared by the servo address map and its surroundings.
// Assumes the map header is on the include path.
package scam_pkg;
   `include "scam_map.svh"

   typedef logic [15:0] scam_word_t;

   typedef enum logic [7:0] {
      scam_err_none = 8'h00,
      scam_err_addr = 8'h02,
      scam_err_range = 8'h03
   } scam_err_e;
endpackage

// File: hw/scam_map.sv
// Address map of the servo drive as seen by the host over the register link.
// Assumes the frame layer delivers one decoded word access per i_req pulse.
//
// Overview of operation
// - Addresses 0x0000..0x02FD pass one-to-one to the parameter store, read and write.
// - Ten-entry read-only alarm history at 0x07F1..0x07FA, cleared by writing 01 to 0x1021.
// - Speed and torque zero offsets read/write; both phase-current offsets read-only.
// - Words 0x0806..0x0816 mirror the local monitor display, read-only.
// - Speed feedback and input speed reference are read-only rpm words.
// - Input and internal torque references are read-only percent of rated torque.
// - Location low word counts single pulses, high word counts units of 10000.
// - Following error counter reads as low and high 16-bit halves.
// - Commanded pulse counter low in single pulses, high in units of 10000.
// - Encoder pulses, input, encoder-line and output pin states are read-only words.
// - Link IO word is read/write and resets to zero, never retained.
// - Main and logic firmware versions read back as read-only digit words.
// - Node jog forward/reverse start only with start signal set; 00 stops.
// - Writing 01 to 0x1028 pauses at node position; 00 cancels the pause.
// - 0x1040 clears encoder alarm; 0x1041 clears multi-turn only with 17-bit encoder.
// - An out-of-range parameter write is discarded and answered as unsuccessful.
// - A link IO bit drives its pin only when both routing parameters enable it.
`timescale 1ns/1ps
`include "scam_map.svh"

module scam_map
   import scam_pkg::*;
#(
   parameter logic [15:0] MAIN_FW_VERSION = `SCAM_MAIN_VER_DEFAULT,  // Arbitrary value.
   parameter logic [15:0] LOGIC_FW_VERSION = `SCAM_LOGIC_VER_DEFAULT // Arbitrary value.
) (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_req,
   input wire logic i_write,
   input wire logic [15:0] i_addr,
   input wire logic [15:0] i_wdata,
   output logic o_ack,
   output logic [15:0] o_rdata,
   output logic [7:0] o_err,
   output logic o_par_we,
   output logic [9:0] o_par_idx,
   output logic [15:0] o_par_wdata,
   input wire logic [15:0] i_par_rdata,
   input wire logic i_par_in_range,
   input wire logic i_alarm_event,
   input wire logic [15:0] i_alarm_code,
   input wire logic [15:0] i_active_alarm_code,
   input wire logic [15:0] i_phase_u_current_offset,
   input wire logic [15:0] i_phase_v_current_offset,
   input wire logic [15:0] i_motor_speed_feedback,
   input wire logic [15:0] i_speed_command_input,
   input wire logic [15:0] i_torque_command_input_pct,
   input wire logic [15:0] i_torque_command_internal_pct,
   input wire logic [15:0] i_encoder_pulse_count,
   input wire logic [15:0] i_input_pin_state,
   input wire logic [15:0] i_encoder_line_state,
   input wire logic [15:0] i_output_pin_state,
   input wire logic [15:0] i_pulse_setting_value,
   input wire logic [15:0] i_location_low,
   input wire logic [15:0] i_location_high,
   input wire logic [31:0] i_following_error,
   input wire logic [15:0] i_commanded_pulses_low,
   input wire logic [15:0] i_commanded_pulses_high,
   input wire logic [15:0] i_load_inertia_ratio,
   input wire logic [15:0] i_motor_overload_ratio,
   input wire logic [15:0] i_winding_temperature,
   input wire logic i_enc_17bit,
   input wire logic [15:0] i_abs_turns_count,
   input wire logic [16:0] i_abs_angle,
   input wire logic i_start_signal,
   input wire logic [15:0] i_io_route_param_a,
   input wire logic [15:0] i_io_route_param_b,
   output logic [15:0] o_speed_ref_offset,
   output logic [15:0] o_torque_ref_offset,
   output logic [15:0] o_link_io_drive,
   output logic [15:0] o_link_io_enable,
   output logic o_alarm_clear,
   output logic o_jog_enable,
   output logic o_jog_fwd,
   output logic o_jog_rev,
   output logic o_node_jog_fwd,
   output logic o_node_jog_rev,
   output logic o_node_pause,
   output logic o_encoder_fault_clear,
   output logic o_turns_clear,
   output logic o_teach_start
);

   // ------------------------------------------------------------------
   // Access decode
   // ------------------------------------------------------------------
   scam_word_t alarm_history [`SCAM_HIST_DEPTH];
   scam_word_t link_io_word;
   scam_word_t next_rdata;
   logic [7:0] next_err;
   logic is_par;
   logic is_hist;
   logic is_cmd;
   logic cmd_on;
   logic cmd_off;
   logic cmd_val_ok;
   logic wr_ok;
   logic [3:0] hist_idx;

   function automatic logic is_cmd_addr(input logic [15:0] a);
      unique case (a)
         `SCAM_CMD_HIST_CLR, `SCAM_CMD_ALARM_CLR, `SCAM_CMD_JOG_EN,
         `SCAM_CMD_JOG_FWD, `SCAM_CMD_JOG_REV, `SCAM_CMD_NODE_FWD,
         `SCAM_CMD_NODE_REV, `SCAM_CMD_NODE_PAUSE, `SCAM_CMD_ENC_CLR,
         `SCAM_CMD_TURNS_CLR, `SCAM_CMD_TEACH: is_cmd_addr = 1'b1;
         default: is_cmd_addr = 1'b0;
      endcase
   endfunction

   function automatic logic cmd_hit(input logic [15:0] a);
      cmd_hit = wr_ok && is_cmd && (i_addr == a);
   endfunction

   assign is_par = (i_addr <= `SCAM_PAR_LAST);
   assign is_hist = (i_addr >= `SCAM_HIST_FIRST) && (i_addr <= `SCAM_HIST_LAST);
   assign hist_idx = 4'(i_addr - `SCAM_HIST_FIRST);
   assign is_cmd = is_cmd_addr(i_addr);
   assign cmd_on = (i_wdata == `SCAM_VAL_ON);
   assign cmd_off = (i_wdata == `SCAM_VAL_OFF);
   assign cmd_val_ok = cmd_on || cmd_off;
   assign wr_ok = i_req && i_write && (next_err == 8'(scam_err_none));

   assign o_par_idx = i_addr[9:0];
   assign o_par_wdata = i_wdata;
   assign o_par_we = wr_ok && is_par;

   // Read data and answer code for the access offered this cycle.
   always_comb begin
      next_rdata = `SCAM_RST_WORD;
      next_err = 8'(scam_err_none);
      if (is_par) begin
         next_rdata = i_par_rdata;
         if (i_write && !i_par_in_range) begin
            next_err = 8'(scam_err_range);
         end
      end else if (is_hist) begin
         next_rdata = alarm_history[hist_idx];
         if (i_write) begin
            next_err = 8'(scam_err_addr);
         end
      end else if (is_cmd) begin
         if (!i_write) begin
            next_err = 8'(scam_err_addr);
         end else if (!cmd_val_ok) begin
            next_err = 8'(scam_err_range);
         end
      end else begin
         unique case (i_addr)
            `SCAM_SPD_OFS: next_rdata = o_speed_ref_offset;
            `SCAM_TRQ_OFS: next_rdata = o_torque_ref_offset;
            `SCAM_LINK_IO: next_rdata = link_io_word;
            default: begin
               if (i_write) begin
                  next_err = 8'(scam_err_addr);
               end
               unique case (i_addr)
                  `SCAM_IU_OFS: next_rdata = i_phase_u_current_offset;
                  `SCAM_IV_OFS: next_rdata = i_phase_v_current_offset;
                  `SCAM_MON_SPD_FB: next_rdata = i_motor_speed_feedback;
                  `SCAM_MON_SPD_IN: next_rdata = i_speed_command_input;
                  `SCAM_MON_TRQ_IN: next_rdata = i_torque_command_input_pct;
                  `SCAM_MON_TRQ_INT: next_rdata = i_torque_command_internal_pct;
                  `SCAM_MON_ENC_PLS: next_rdata = i_encoder_pulse_count;
                  `SCAM_MON_IN_PINS: next_rdata = i_input_pin_state;
                  `SCAM_MON_ENC_LINES: next_rdata = i_encoder_line_state;
                  `SCAM_MON_OUT_PINS: next_rdata = i_output_pin_state;
                  `SCAM_MON_PLS_SET: next_rdata = i_pulse_setting_value;
                  `SCAM_MON_LOC_LO: next_rdata = i_location_low;
                  `SCAM_MON_LOC_HI: next_rdata = i_location_high;
                  `SCAM_MON_FERR_LO: next_rdata = i_following_error[15:0];
                  `SCAM_MON_FERR_HI: next_rdata = i_following_error[31:16];
                  `SCAM_MON_CMDP_LO: next_rdata = i_commanded_pulses_low;
                  `SCAM_MON_CMDP_HI: next_rdata = i_commanded_pulses_high;
                  `SCAM_MON_INERTIA: next_rdata = i_load_inertia_ratio;
                  `SCAM_MON_OVERLOAD: next_rdata = i_motor_overload_ratio;
                  `SCAM_ALARM_NOW: next_rdata = i_active_alarm_code;
                  `SCAM_WINDING_TEMP: next_rdata = i_winding_temperature;
                  `SCAM_MAIN_VER: next_rdata = MAIN_FW_VERSION;
                  `SCAM_LOGIC_VER: next_rdata = LOGIC_FW_VERSION;
                  `SCAM_ABS_TURNS: begin
                     next_rdata = i_enc_17bit ? i_abs_turns_count : `SCAM_RST_WORD;
                  end
                  `SCAM_ABS_ANGLE_LO: begin
                     next_rdata = i_enc_17bit ? i_abs_angle[15:0] : `SCAM_RST_WORD;
                  end
                  `SCAM_ABS_ANGLE_HI: begin
                     next_rdata = i_enc_17bit ? 16'(i_abs_angle[16]) : `SCAM_RST_WORD;
                  end
                  default: next_err = 8'(scam_err_addr);
               endcase
            end
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Answer to the host
   // ------------------------------------------------------------------
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         o_ack <= 1'b0;
         o_rdata <= `SCAM_RST_WORD;
         o_err <= 8'(scam_err_none);
      end else begin
         o_ack <= i_req;
         if (i_req) begin
            o_rdata <= i_write ? `SCAM_RST_WORD : next_rdata;
            o_err <= next_err;
         end
      end
   end

   // ------------------------------------------------------------------
   // Read/write words
   // ------------------------------------------------------------------
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         o_speed_ref_offset <= `SCAM_RST_WORD;
         o_torque_ref_offset <= `SCAM_RST_WORD;
         link_io_word <= `SCAM_RST_WORD;
      end else if (wr_ok) begin
         if (i_addr == `SCAM_SPD_OFS) begin
            o_speed_ref_offset <= i_wdata;
         end
         if (i_addr == `SCAM_TRQ_OFS) begin
            o_torque_ref_offset <= i_wdata;
         end
         if (i_addr == `SCAM_LINK_IO) begin
            link_io_word <= i_wdata;
         end
      end
   end

   // Only bits routed to communication by both parameters reach the pins.
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         o_link_io_enable <= `SCAM_RST_WORD;
         o_link_io_drive <= `SCAM_RST_WORD;
      end else begin
         o_link_io_enable <= i_io_route_param_a & i_io_route_param_b;
         o_link_io_drive <= link_io_word & i_io_route_param_a & i_io_route_param_b;
      end
   end

   // ------------------------------------------------------------------
   // Alarm history
   // ------------------------------------------------------------------
   // A new alarm in the clearing cycle survives as the latest entry.
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         for (int k = 0; k < `SCAM_HIST_DEPTH; k++) begin
            alarm_history[k] <= `SCAM_RST_WORD;
         end
      end else if (cmd_hit(`SCAM_CMD_HIST_CLR) && cmd_on) begin
         alarm_history[0] <= i_alarm_event ? i_alarm_code : `SCAM_RST_WORD;
         for (int k = 1; k < `SCAM_HIST_DEPTH; k++) begin
            alarm_history[k] <= `SCAM_RST_WORD;
         end
      end else if (i_alarm_event) begin
         alarm_history[0] <= i_alarm_code;
         for (int k = 1; k < `SCAM_HIST_DEPTH; k++) begin
            alarm_history[k] <= alarm_history[k - 1];
         end
      end
   end

   // ------------------------------------------------------------------
   // Command words
   // ------------------------------------------------------------------
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         o_alarm_clear <= 1'b0;
         o_encoder_fault_clear <= 1'b0;
         o_turns_clear <= 1'b0;
         o_teach_start <= 1'b0;
      end else begin
         o_alarm_clear <= cmd_hit(`SCAM_CMD_ALARM_CLR) && cmd_on;
         o_encoder_fault_clear <= cmd_hit(`SCAM_CMD_ENC_CLR) && cmd_on;
         o_turns_clear <= cmd_hit(`SCAM_CMD_TURNS_CLR) && cmd_on && i_enc_17bit;
         o_teach_start <= cmd_hit(`SCAM_CMD_TEACH) && cmd_on;
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         o_jog_enable <= 1'b0;
         o_jog_fwd <= 1'b0;
         o_jog_rev <= 1'b0;
      end else begin
         if (cmd_hit(`SCAM_CMD_JOG_EN)) begin
            o_jog_enable <= cmd_on;
         end
         if (cmd_hit(`SCAM_CMD_JOG_FWD)) begin
            o_jog_fwd <= cmd_on;
         end
         if (cmd_hit(`SCAM_CMD_JOG_REV)) begin
            o_jog_rev <= cmd_on;
         end
      end
   end

   // A start request without the start signal is ignored; a stop always acts.
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         o_node_jog_fwd <= 1'b0;
         o_node_jog_rev <= 1'b0;
         o_node_pause <= 1'b0;
      end else begin
         if (cmd_hit(`SCAM_CMD_NODE_FWD) && (cmd_off || i_start_signal)) begin
            o_node_jog_fwd <= cmd_on;
         end
         if (cmd_hit(`SCAM_CMD_NODE_REV) && (cmd_off || i_start_signal)) begin
            o_node_jog_rev <= cmd_on;
         end
         if (cmd_hit(`SCAM_CMD_NODE_PAUSE)) begin
            o_node_pause <= cmd_on;
         end
      end
   end

endmodule // scam_map

// File: dv/scam_par_store.sv
// Parameter store model standing behind the map's parameter port.
// Assumes index and data reach it combinationally from the map.
`timescale 1ns/1ps
module scam_par_store #(
   parameter logic [15:0] LIMIT = 16'h7fff
) (
   input wire logic i_clk_sys,
   input wire logic i_we,
   input wire logic [9:0] i_idx,
   input wire logic [15:0] i_wdata,
   output logic [15:0] o_rdata,
   output logic o_in_range
);
   // ---------------------------------------------------------------
   // Storage
   // ---------------------------------------------------------------
   // Words never written read as unknown, so a stray read shows up.
   logic [15:0] mem [766];
   assign o_in_range = (i_wdata <= LIMIT);
   assign o_rdata = (i_idx < 10'h2fe) ? mem[i_idx] : 16'h0000;
   always_ff @(posedge i_clk_sys) begin
      if (i_we && i_idx < 10'h2fe) begin
         mem[i_idx] <= i_wdata;
      end
   end
endmodule // scam_par_store

// File: dv/scam_map_chk.sv
// Concurrent checks on the ports of the servo address map.
// Assumes it is bound to every instance of scam_map.
`timescale 1ns/1ps
module scam_map_chk (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_req,
   input wire logic i_write,
   input wire logic [15:0] i_addr,
   input wire logic [15:0] i_wdata,
   input wire logic o_ack,
   input wire logic [15:0] o_rdata,
   input wire logic [7:0] o_err,
   input wire logic o_par_we,
   input wire logic i_par_in_range,
   input wire logic i_start_signal,
   input wire logic i_enc_17bit,
   input wire logic [16:0] i_abs_angle,
   input wire logic [15:0] i_io_route_param_a,
   input wire logic [15:0] i_io_route_param_b,
   input wire logic [15:0] o_link_io_enable,
   input wire logic o_alarm_clear,
   input wire logic o_encoder_fault_clear,
   input wire logic o_node_jog_fwd,
   input wire logic o_turns_clear,
   input wire logic o_teach_start
);
   // ---------------------------------------------------------------
   // Properties
   // ---------------------------------------------------------------
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);
   sequence s_wr(a, v);
      i_req && i_write && i_addr == a && i_wdata == v;
   endsequence
   sequence s_pulse(sig);
      sig ##1 !sig;
   endsequence
   sequence s_idle(a);
      !(i_req && i_addr == a);
   endsequence
   a_ack_next: assert property (i_req |=> o_ack) else $error("request not answered");
   a_ack_cause: assert property (!i_req |=> !o_ack) else $error("answer without request");
   a_par_accept: assert property (o_par_we |-> i_req && i_write && i_par_in_range
      && i_addr <= 16'h02fd) else $error("parameter write without cause");
   a_par_range: assert property (i_req && i_write && !i_par_in_range
      && i_addr <= 16'h02fd |=> o_err == 8'h03) else $error("out of range write not refused");
   a_mon_ro: assert property (i_req && i_write && i_addr inside {[16'h0806:16'h0818]}
      |=> o_err == 8'h02) else $error("monitor word accepted a write");
   a_io_enable: assert property (!$past(i_rst) |-> o_link_io_enable ==
      ($past(i_io_route_param_a) & $past(i_io_route_param_b))) else $error("io enable wrong");
   a_node_start: assert property ((s_wr(16'h1026, 16'h0001) ##0
      (!i_start_signal && !o_node_jog_fwd)) |=> !o_node_jog_fwd) else $error("node jog ran");
   a_clear_pulse: assert property (s_wr(16'h1022, 16'h0001) ##1 s_idle(16'h1022)
      |-> s_pulse(o_alarm_clear)) else $error("alarm clear pulse wrong");
   a_teach_pulse: assert property (s_wr(16'h1070, 16'h0001) ##1 s_idle(16'h1070)
      |-> s_pulse(o_teach_start)) else $error("teach start pulse wrong");
   a_encoder_clear: assert property (s_wr(16'h1040, 16'h0001) ##1 s_idle(16'h1040)
      |-> s_pulse(o_encoder_fault_clear)) else $error("encoder clear pulse wrong");
   a_turns_pulse: assert property ((s_wr(16'h1041, 16'h0001) ##0 i_enc_17bit)
      ##1 s_idle(16'h1041) |-> s_pulse(o_turns_clear)) else $error("turns clear pulse wrong");
   a_turns_gate: assert property (o_turns_clear |-> $past(i_enc_17bit))
      else $error("turns clear without wide encoder");
   a_angle_high: assert property (i_req && !i_write && i_addr == 16'h1012 && i_enc_17bit
      |=> o_rdata == {15'h0000, $past(i_abs_angle[16])}) else $error("angle high word wrong");
endmodule // scam_map_chk

bind scam_map scam_map_chk u_chk (.i_clk_sys, .i_rst, .i_req, .i_write, .i_addr, .i_wdata,
   .o_ack, .o_rdata, .o_err, .o_par_we, .i_par_in_range, .i_start_signal, .i_enc_17bit,
   .i_abs_angle, .i_io_route_param_a, .i_io_route_param_b, .o_link_io_enable, .o_alarm_clear,
   .o_encoder_fault_clear, .o_node_jog_fwd, .o_turns_clear, .o_teach_start);

// File: dv/testbench.sv
// Self-checking bench for the servo address map.
// Assumes the checker binds itself and the store model holds the parameters.
`timescale 1ns/1ps
`include "scam_map.svh"
module testbench;
   import scam_pkg::*;
   // ---------------------------------------------------------------
   // Stimulus and checking
   // ---------------------------------------------------------------
   localparam logic [15:0] LIMIT = 16'h7fff;
   localparam logic [15:0] Z = 16'h0000;
   logic i_clk_sys = 1'b0, i_rst = 1'b1, i_req = 1'b0, i_write = 1'b0, i_alarm_event = 1'b0;
   logic i_enc_17bit = 1'b1, i_start_signal = 1'b0;
   logic [15:0] i_addr = Z, i_wdata = Z, i_alarm_code = Z, i_abs_turns_count = Z, w, a;
   logic [15:0] i_io_route_param_a = Z, i_io_route_param_b = Z, mon [19], ofs [2];
   logic [16:0] i_abs_angle = 17'h00000;
   logic o_ack, o_par_we, i_par_in_range, o_alarm_clear, o_jog_enable, o_jog_fwd, o_jog_rev;
   logic o_node_jog_fwd, o_node_jog_rev, o_node_pause, o_encoder_fault_clear, o_turns_clear;
   logic o_teach_start;
   logic [15:0] o_rdata, o_par_wdata, i_par_rdata, o_speed_ref_offset, o_torque_ref_offset;
   logic [15:0] o_link_io_drive, o_link_io_enable, cmds [4];
   logic [9:0] o_par_idx;
   logic [7:0] o_err;
   logic [23:0] q [$], note;
   int fail_count = 0, checked = 0;
   always #2 i_clk_sys = ~i_clk_sys;
   scam_map uut (.i_clk_sys, .i_rst, .i_req, .i_write, .i_addr, .i_wdata, .o_ack, .o_rdata,
      .o_err, .o_par_we, .o_par_idx, .o_par_wdata, .i_par_rdata, .i_par_in_range,
      .i_alarm_event, .i_alarm_code, .i_active_alarm_code(mon[17]),
      .i_phase_u_current_offset(ofs[0]), .i_phase_v_current_offset(ofs[1]),
      .i_motor_speed_feedback(mon[0]), .i_speed_command_input(mon[1]),
      .i_torque_command_input_pct(mon[2]), .i_torque_command_internal_pct(mon[3]),
      .i_encoder_pulse_count(mon[4]), .i_input_pin_state(mon[5]),
      .i_encoder_line_state(mon[6]), .i_output_pin_state(mon[7]),
      .i_pulse_setting_value(mon[8]), .i_location_low(mon[9]), .i_location_high(mon[10]),
      .i_following_error({mon[12], mon[11]}), .i_commanded_pulses_low(mon[13]),
      .i_commanded_pulses_high(mon[14]), .i_load_inertia_ratio(mon[15]),
      .i_motor_overload_ratio(mon[16]), .i_winding_temperature(mon[18]), .i_enc_17bit,
      .i_abs_turns_count, .i_abs_angle, .i_start_signal, .i_io_route_param_a,
      .i_io_route_param_b, .o_speed_ref_offset, .o_torque_ref_offset, .o_link_io_drive,
      .o_link_io_enable, .o_alarm_clear, .o_jog_enable, .o_jog_fwd, .o_jog_rev, .o_node_jog_fwd,
      .o_node_jog_rev, .o_node_pause, .o_encoder_fault_clear, .o_turns_clear, .o_teach_start);
   scam_par_store #(.LIMIT(LIMIT)) u_store (.i_clk_sys, .i_we(o_par_we), .i_idx(o_par_idx),
      .i_wdata(o_par_wdata), .o_rdata(i_par_rdata), .o_in_range(i_par_in_range));
   task automatic conclude();
      $display("checked=%0d fail_count=%0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // One access; the expected answer is queued for the watcher below.
   task automatic acc(input logic wr, input logic [15:0] ad, input logic [15:0] d,
      input logic [15:0] er, input logic [7:0] e);
      @(posedge i_clk_sys);
      q.push_back({er, e});
      i_req <= 1'b1;
      i_write <= wr;
      i_addr <= ad;
      i_wdata <= d;
      @(posedge i_clk_sys);
      i_req <= 1'b0;
      for (int n = 0; n < 4 && q.size() != 0; n++) @(negedge i_clk_sys);
      if (q.size() != 0) begin
         fail_count++;
         conclude();
      end
   endtask
   always @(negedge i_clk_sys) begin
      if (o_ack === 1'b1) begin
         note = (q.size() != 0) ? q.pop_front() : 24'hffffff;
         chk(o_rdata, note[23:8]);
         chk({8'h00, o_err}, {8'h00, note[7:0]});
      end
   end
   initial begin
      foreach (mon[k]) mon[k] = Z;
      ofs = '{Z, Z};
      cmds = '{16'h1023, 16'h1024, 16'h1025, 16'h1028};
      void'($urandom(32'hbf960cf0));
      repeat (6) @(posedge i_clk_sys);
      foreach (mon[k]) mon[k] <= 16'($urandom);
      ofs <= '{16'($urandom), 16'($urandom)};
      i_io_route_param_a <= 16'($urandom);
      i_io_route_param_b <= 16'($urandom);
      i_abs_turns_count <= 16'($urandom);
      i_abs_angle <= 17'($urandom);
      i_rst <= 1'b0;
      acc(0, `SCAM_MAIN_VER, Z, `SCAM_MAIN_VER_DEFAULT, 8'h00);
      acc(0, `SCAM_LOGIC_VER, Z, `SCAM_LOGIC_VER_DEFAULT, 8'h00);
      for (int k = 0; k < 19; k++) begin
         acc(0, 16'h0806 + 16'(k), Z, mon[k], 8'h00);
         acc(1, 16'h0806 + 16'(k), 16'h1234, Z, 8'h02);
      end
      for (int k = 0; k < 2; k++) begin
         w = 16'($urandom);
         acc(0, 16'h07fb + 16'(k), Z, Z, 8'h00);
         acc(1, 16'h07fb + 16'(k), w, Z, 8'h00);
         acc(0, 16'h07fb + 16'(k), Z, w, 8'h00);
         chk(k ? o_torque_ref_offset : o_speed_ref_offset, w);
         acc(0, 16'h07fd + 16'(k), Z, ofs[k], 8'h00);
         acc(1, 16'h07fd + 16'(k), w, Z, 8'h02);
      end
      for (int k = 0; k < 3; k++) begin
         a = (k == 2) ? 16'h02fd : 16'($urandom_range(0, 16'h02fc));
         w = 16'($urandom) & LIMIT;
         acc(1, a, w, Z, 8'h00);
         acc(1, a, w | 16'h8000, Z, 8'h03);
         acc(0, a, Z, w, 8'h00);
      end
      acc(0, 16'h02fe, Z, Z, 8'h02);
      for (int k = 0; k < 11; k++) begin
         @(posedge i_clk_sys);
         i_alarm_event <= 1'b1;
         i_alarm_code <= 16'h0a00 + 16'(k);
         @(posedge i_clk_sys);
         i_alarm_event <= 1'b0;
      end
      for (int k = 0; k < 10; k++) begin
         acc(0, 16'h07f1 + 16'(k), Z, 16'h0a0a - 16'(k), 8'h00);
      end
      acc(1, 16'h07f1, 16'h0001, Z, 8'h02);
      acc(0, 16'h1021, Z, Z, 8'h02);
      acc(1, 16'h1021, 16'h0001, Z, 8'h00);
      acc(0, 16'h07fa, Z, Z, 8'h00);
      for (int v = 1; v >= 0; v--) begin
         for (int j = 0; j < 4; j++) acc(1, cmds[j], 16'(v), Z, 8'h00);
         chk({12'h000, o_jog_enable, o_jog_fwd, o_jog_rev, o_node_pause},
            16'(v * 15));
      end
      acc(1, 16'h1023, 16'h0002, Z, 8'h03);
      acc(1, 16'h1026, 16'h0001, Z, 8'h00);
      chk({15'h0000, o_node_jog_fwd}, Z);
      @(posedge i_clk_sys);
      i_start_signal <= 1'b1;
      for (int j = 0; j < 2; j++) begin
         acc(1, 16'h1026 + 16'(j), 16'h0001, Z, 8'h00);
         chk({14'h0000, o_node_jog_fwd, o_node_jog_rev}, 16'(2 >> j));
         acc(1, 16'h1026 + 16'(j), Z, Z, 8'h00);
      end
      acc(1, 16'h1022, 16'h0001, Z, 8'h00);
      acc(0, 16'h1022, Z, Z, 8'h02);
      acc(1, 16'h1040, 16'h0001, Z, 8'h00);
      acc(1, 16'h1041, 16'h0001, Z, 8'h00);
      acc(1, 16'h1070, 16'h0001, Z, 8'h00);
      acc(0, 16'h1010, Z, i_abs_turns_count, 8'h00);
      acc(0, 16'h1011, Z, i_abs_angle[15:0], 8'h00);
      acc(0, 16'h1012, Z, {15'h0000, i_abs_angle[16]}, 8'h00);
      @(posedge i_clk_sys);
      i_enc_17bit <= 1'b0;
      acc(1, 16'h1041, 16'h0001, Z, 8'h00);
      acc(0, 16'h1010, Z, Z, 8'h00);
      w = 16'($urandom);
      acc(1, 16'h0900, w, Z, 8'h00);
      acc(0, 16'h0900, Z, w, 8'h00);
      chk(o_link_io_drive, w & i_io_route_param_a & i_io_route_param_b);
      chk(o_link_io_enable, i_io_route_param_a & i_io_route_param_b);
      @(posedge i_clk_sys);
      i_rst <= 1'b1;
      repeat (2) @(posedge i_clk_sys);
      i_rst <= 1'b0;
      acc(0, 16'h0900, Z, Z, 8'h00);
      conclude();
   end
endmodule // testbench
